// ==== src/spe_pkg.sv ====
/*
  Constants and types shared by the serial program/erase control block.
  Assumes a 200 MHz core clock and a programmer-driven serial clock.
*/
package spe_pkg;
  // Core clock and self-timed bulk erase; erase time is a plain default
  localparam int unsigned CLK_PERIOD_NS     = 5;
  localparam int unsigned ERASE_WAIT_US     = 5000;
  localparam int unsigned ERASE_CYCLES_DFLT = (ERASE_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  localparam int unsigned ECNT_W            = 24;

  // Serial frame: 4-bit command then 16-bit payload, LSB first
  localparam int unsigned CMD_BITS   = 4;
  localparam int unsigned FRAME_BITS = 20;
  localparam int unsigned ADDR_W     = 22;

  localparam logic [3:0] CMD_CORE    = 4'h0;
  localparam logic [3:0] CMD_TW      = 4'hc;
  localparam logic [3:0] CMD_TW_INC2 = 4'hd;
  localparam logic [3:0] CMD_TW_PROG = 4'hf;

  // Core instruction subset reachable through the command port
  localparam logic [7:0] OP_MOVLW = 8'h0e;
  localparam logic [7:0] OP_MOVWF = 8'h6e;
  localparam logic [3:0] OP_BSF   = 4'h8;
  localparam logic [3:0] OP_BCF   = 4'h9;
  localparam logic [7:0] SFR_TPU  = 8'hf8;
  localparam logic [7:0] SFR_TPH  = 8'hf7;
  localparam logic [7:0] SFR_TPL  = 8'hf6;
  localparam logic [7:0] SFR_FCTL = 8'ha6;

  // flash_control bit positions
  localparam int unsigned FC_PSPACE = 7;
  localparam int unsigned FC_CSPACE = 6;
  localparam int unsigned FC_ERASE  = 4;
  localparam int unsigned FC_WRITE_ENABLE_BIT   = 2;
  localparam int unsigned FC_LAUNCH = 1;

  // Table-write targets
  localparam logic [21:0] SEL_LO_ADDR = 22'h3c0004;
  localparam logic [21:0] SEL_HI_ADDR = 22'h3c0005;
  localparam logic [21:0] CFG4L_ADDR  = 22'h300006;
  localparam logic [21:0] PROT_ADDR   = 22'h300008;
  localparam logic [21:0] CODE_TOP    = 22'h017fff;

  // config_byte_four_low layout and reset
  localparam int unsigned CF_ALT    = 0;
  localparam int unsigned CF_BSIZ   = 1;
  localparam logic        ALT_RST   = 1'b0;
  localparam logic [1:0]  BSIZ_RST  = 2'h1;

  // Boot region limits for 1K, 2K and 4K words
  localparam logic [21:0] BOOT_LIM_1K = 22'h0007ff;
  localparam logic [21:0] BOOT_LIM_2K = 22'h000fff;
  localparam logic [21:0] BOOT_LIM_4K = 22'h001fff;
  localparam int unsigned BLOCK_SHIFT = 14;
  localparam logic [2:0]  BOOT_TAG    = 3'h7;

  // Bulk erase selector values and region mask layout
  localparam logic [15:0] SEL_CHIP   = 16'h3f8f;
  localparam logic [15:0] SEL_DATA   = 16'h0084;
  localparam logic [15:0] SEL_BOOT   = 16'h0081;
  localparam logic [15:0] SEL_CFG    = 16'h0082;
  localparam logic [7:0]  SEL_BLK_LO = 8'h80;
  localparam int unsigned NUM_BLOCKS = 6;
  localparam int unsigned EM_BOOT    = 6;
  localparam int unsigned EM_CFG     = 7;
  localparam int unsigned EM_DATA    = 8;
  localparam int unsigned EM_W       = 9;

  typedef enum logic [1:0] {
    OWN_IDLE = 2'h0,
    OWN_DEF  = 2'h1,
    OWN_ALT  = 2'h2
  } spe_owner_t;

  typedef enum logic [1:0] {
    PG_NONE  = 2'h0,
    PG_WRITE = 2'h1,
    PG_ERASE = 2'h2
  } spe_prog_t;
endpackage

// ==== src/spe_link.sv ====
/*
  Serial link receiver for one programming port: shifts command and payload,
  and times the programming hold phase on the link clock.
  Assumes session_in and arm_in are core-clock levels, held many link clocks.
*/
`timescale 1ns/10ps
module spe_link (
  input  wire logic                             link_clk_in,
  input  wire logic                             data_in,
  input  wire logic                             session_in,
  input  wire logic                             arm_in,
  output logic                                  frame_tog_out,
  output logic [spe_pkg::FRAME_BITS-1:0]        frame_out,
  output logic                                  cmd_tog_out,
  output logic [spe_pkg::CMD_BITS-1:0]          cmd_out,
  output logic                                  hold_out
);
  import spe_pkg::*;

  // Falling-edge state
  typedef struct packed {
    logic                  sess_s1, sess_s2;
    logic [4:0]            cnt;
    logic [FRAME_BITS-1:0] sh;
    logic [FRAME_BITS-1:0] frame;
    logic                  ftog;
    logic [CMD_BITS-1:0]   cmd;
    logic                  ctog;
    logic                  clr_tog;
  } spe_lneg_t;

  // Rising-edge state; hold is set/clear toggle pair across both edges
  typedef struct packed {
    logic arm_s1, arm_s2;
    logic set_tog;
  } spe_lpos_t;

  spe_lneg_t r, n;
  spe_lpos_t p, pn;

  assign hold_out      = p.set_tog ^ r.clr_tog;
  assign frame_tog_out = r.ftog;
  assign frame_out     = r.frame;
  assign cmd_tog_out   = r.ctog;
  assign cmd_out       = r.cmd;

  always_comb begin
    n         = r;
    pn        = p;
    n.sess_s1 = session_in;
    n.sess_s2 = r.sess_s1;
    pn.arm_s1 = arm_in;
    pn.arm_s2 = p.arm_s1;
    if (!r.sess_s2) begin
      // Leaving or not yet in a session acts as the link reset
      n.cnt      = '0;
      n.sh       = '0;
      n.frame    = '0;
      n.ftog     = 1'b0;
      n.cmd      = '0;
      n.ctog     = 1'b0;
      n.clr_tog  = 1'b0;
      pn.set_tog = 1'b0;
    end else begin
      n.sh = {data_in, r.sh[FRAME_BITS-1:1]};
      if (r.cnt == 5'(CMD_BITS - 1)) begin
        n.cmd  = {data_in, r.sh[FRAME_BITS-1:FRAME_BITS-3]};
        n.ctog = !r.ctog;
      end
      if (r.cnt == 5'(FRAME_BITS - 1)) begin
        n.frame = {data_in, r.sh[FRAME_BITS-1:1]};
        n.ftog  = !r.ftog;
        n.cnt   = '0;
      end else begin
        n.cnt = r.cnt + 5'h1;
      end
      // Hold starts on the 4th rising edge, ends on its falling edge
      if (hold_out) begin
        n.clr_tog = !r.clr_tog;
      end
      if (r.cnt == 5'(CMD_BITS - 1) && p.arm_s2 && !hold_out) begin
        pn.set_tog = !p.set_tog;
      end
    end
  end

  always_ff @(negedge link_clk_in) begin
    r <= n;
  end

  always_ff @(posedge link_clk_in) begin
    p <= pn;
  end

  frame_len_a: assert property (@(negedge link_clk_in) disable iff (!r.sess_s2)
    $changed(r.ftog) |-> $past(r.cnt) == 5'(FRAME_BITS - 1))
    else $error("frame completed off the 20-bit boundary");

  hold_drop_a: assert property (@(negedge link_clk_in) disable iff (!r.sess_s2)
    hold_out |=> !hold_out)
    else $error("hold survived the falling serial clock");
endmodule

// ==== src/spe_ctrl.sv ====
/*
  Serial program/erase control: port ownership, core-instruction decode,
  flash_control launch, bulk erase selector and self-timed bulk erase.
  Assumes the programmer keeps to the serial protocol; enable pins are async.
*/
`timescale 1ns/10ps
// What this block does
// - Boot region below limit, blocks protect independently
// - Sixteen-Kbyte blocks, 96-Kbyte code space
// - Two-bit field sizes boot region 1/2/4K
// - Alternate port works when its bit set
// - Default port stays usable regardless
// - First enabled port owns session
// - Alternate bit writable only from default port
// - Code space: bit7 one, bit6 zero
// - No launch without prior write enable
// - Erase-select bit turns launch into row erase
// - Launch bit starts selected sequence
// - Two byte registers select bulk erase regions
// - Bulk erase clears protection, only way off
// - Chip, data, boot, config selector decode
// - One-hot high byte erases code blocks 0-5
// - Self-timed erase from 4th clock, commands ignored
// - Commands shift in LSB first
// - Programming lasts while 4th clock held high
module spe_ctrl #(
  parameter int unsigned ERASE_CYCLES = spe_pkg::ERASE_CYCLES_DFLT
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       default_prog_enable_pin_in,
  input  wire logic                       alt_prog_enable_pin_in,
  input  wire logic                       prog_serial_clock_in,
  input  wire logic                       prog_serial_data_pin_in,
  output logic                            prog_serial_data_pin_out,
  output logic                            prog_serial_data_pin_oe_out,
  input  wire logic                       alt_serial_clock_pin_in,
  input  wire logic                       alt_serial_data_pin_in,
  output logic                            alt_serial_data_pin_out,
  output logic                            alt_serial_data_pin_oe_out,
  output logic [1:0]                      prog_owner_out,
  output logic [spe_pkg::ADDR_W-1:0]      row_addr_out,
  output logic [2:0]                      row_block_out,
  output logic                            row_write_out,
  output logic                            row_erase_out,
  output logic                            bulk_erase_busy_out,
  output logic [spe_pkg::EM_W-1:0]        bulk_erase_regions_out,
  output logic [7:0]                      code_protect_out,
  output logic [7:0]                      flash_control_out,
  output logic [15:0]                     bulk_erase_select_out,
  output logic                            alt_port_enable_bit_out,
  output logic [1:0]                      boot_region_size_field_out,
  output logic [spe_pkg::ADDR_W-1:0]      boot_limit_out
);
  import spe_pkg::*;

  typedef struct packed {
    logic                den_s1, den_s2, aen_s1, aen_s2;
    logic [1:0]          ft_s1, ft_s2, ft_s3;
    logic [1:0]          ct_s1, ct_s2, ct_s3;
    logic [1:0]          hd_s1, hd_s2, hd_s3;
    spe_owner_t          owner;
    spe_prog_t           prog;
    logic                arm;
    logic [1:0]          sess, armo;
    logic [7:0]          w;
    logic [ADDR_W-1:0]   tp;
    logic [7:0]          fctl, sel_lo, sel_hi;
    logic                alt_bit;
    logic [1:0]          bsize;
    logic [7:0]          prot;
    logic [2:0]          blk;
    logic [ADDR_W-1:0]   blim;
    logic                erase_armed, busy;
    logic [ECNT_W-1:0]   ecnt;
    logic [EM_W-1:0]     emask;
  } spe_state_t;

  localparam spe_state_t ST_RST = '{owner: OWN_IDLE, prog: PG_NONE, bsize: BSIZ_RST,
                                    blim: BOOT_LIM_2K, blk: BOOT_TAG, alt_bit: ALT_RST,
                                    default: '0};

  spe_state_t r, n;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port link receivers on their own serial clocks

  logic [1:0]                 lclk, ldat, lftog, lctog, lhold;
  logic [1:0][FRAME_BITS-1:0] lframe;
  logic [1:0][CMD_BITS-1:0]   lcmd;

  assign lclk = {alt_serial_clock_pin_in, prog_serial_clock_in};
  assign ldat = {alt_serial_data_pin_in, prog_serial_data_pin_in};

  for (genvar g = 0; g < 2; g++) begin : g_port
    spe_link u_link (
      .link_clk_in   (lclk[g]),
      .data_in       (ldat[g]),
      .session_in    (r.sess[g]),
      .arm_in        (r.armo[g]),
      .frame_tog_out (lftog[g]),
      .frame_out     (lframe[g]),
      .cmd_tog_out   (lctog[g]),
      .cmd_out       (lcmd[g]),
      .hold_out      (lhold[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic [EM_W-1:0] erase_decode(input logic [15:0] s);
    logic [EM_W-1:0] m;
    m = '0;
    if (s == SEL_CHIP) begin
      m = '1;
    end else if (s == SEL_DATA) begin
      m[EM_DATA] = 1'b1;
    end else if (s == SEL_BOOT) begin
      m[EM_BOOT] = 1'b1;
    end else if (s == SEL_CFG) begin
      m[EM_CFG] = 1'b1;
    end else if (s[7:0] == SEL_BLK_LO && s[15:8+NUM_BLOCKS] == '0 && |s[15:8]
                 && (s[15:8] & (s[15:8] - 8'h1)) == 8'h0) begin
      m[NUM_BLOCKS-1:0] = s[8+NUM_BLOCKS-1:8];
    end
    return m;
  endfunction

  function automatic logic [ADDR_W-1:0] boot_limit(input logic [1:0] b);
    logic [ADDR_W-1:0] l;
    l = BOOT_LIM_4K;
    if (b == 2'h0) begin
      l = BOOT_LIM_1K;
    end else if (b == 2'h1) begin
      l = BOOT_LIM_2K;
    end
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0]            fev, cev;
    logic                  pi, hfall;
    logic [FRAME_BITS-1:0] fr;
    logic [15:0]           pl;
    logic [7:0]            bin;
    logic [EM_W-1:0]       m;
    n      = r;
    fev    = r.ft_s2 ^ r.ft_s3;
    cev    = r.ct_s2 ^ r.ct_s3;
    pi     = (r.owner == OWN_ALT);
    fr     = lframe[pi];
    pl     = fr[FRAME_BITS-1:CMD_BITS];
    bin    = r.tp[0] ? pl[15:8] : pl[7:0];
    hfall  = r.hd_s3[pi] && !r.hd_s2[pi];
    m      = erase_decode({r.sel_hi, r.sel_lo});

    // Async pins and link toggles: two flops before any use
    n.den_s1 = default_prog_enable_pin_in;
    n.den_s2 = r.den_s1;
    n.aen_s1 = alt_prog_enable_pin_in;
    n.aen_s2 = r.aen_s1;
    n.ft_s1  = lftog;
    n.ft_s2  = r.ft_s1;
    n.ft_s3  = r.ft_s2;
    n.ct_s1  = lctog;
    n.ct_s2  = r.ct_s1;
    n.ct_s3  = r.ct_s2;
    n.hd_s1  = lhold;
    n.hd_s2  = r.hd_s1;
    n.hd_s3  = r.hd_s2;

    // First enable seen wins; the other is ignored till the session ends
    unique case (r.owner)
      OWN_IDLE: begin
        if (r.den_s2) begin
          n.owner = OWN_DEF;
        end else if (r.aen_s2 && r.alt_bit) begin
          n.owner = OWN_ALT;
        end
      end
      OWN_DEF: begin
        if (!r.den_s2) begin
          n.owner = OWN_IDLE;
        end
      end
      OWN_ALT: begin
        if (!r.aen_s2) begin
          n.owner = OWN_IDLE;
        end
      end
      default: begin
        n.owner = OWN_IDLE;
      end
    endcase

    // Frames are ignored while a bulk erase runs; link keeps counting zeros
    if (r.owner != OWN_IDLE && !r.busy && fev[pi]) begin
      case (fr[CMD_BITS-1:0])
        CMD_CORE: begin
          if (pl[15:8] == OP_MOVLW) begin
            n.w = pl[7:0];
          end else if (pl[15:8] == OP_MOVWF) begin
            if (pl[7:0] == SFR_TPU) begin
              n.tp[21:16] = r.w[5:0];
            end else if (pl[7:0] == SFR_TPH) begin
              n.tp[15:8] = r.w;
            end else if (pl[7:0] == SFR_TPL) begin
              n.tp[7:0] = r.w;
            end else if (pl[7:0] == SFR_FCTL) begin
              n.fctl = r.w;
            end
          end else if (pl[7:0] == SFR_FCTL && pl[15:12] == OP_BSF) begin
            n.fctl[pl[11:9]] = 1'b1;
          end else if (pl[7:0] == SFR_FCTL && pl[15:12] == OP_BCF) begin
            n.fctl[pl[11:9]] = 1'b0;
          end
        end
        CMD_TW: begin
          if (r.tp == SEL_LO_ADDR) begin
            n.sel_lo      = bin;
            n.erase_armed = 1'b1;
          end else if (r.tp == SEL_HI_ADDR) begin
            n.sel_hi = bin;
          end else if (r.tp == CFG4L_ADDR) begin
            n.bsize = bin[CF_BSIZ +: 2];
            if (r.owner == OWN_DEF) begin
              n.alt_bit = bin[CF_ALT];
            end
          end else if (r.tp == PROT_ADDR) begin
            // Written zeros turn protection on; nothing here turns it off
            n.prot = r.prot | ~bin;
          end
        end
        CMD_TW_INC2: begin
          n.tp = r.tp + 22'h2;
        end
        CMD_TW_PROG: begin
          if (r.fctl[FC_WRITE_ENABLE_BIT] && r.fctl[FC_PSPACE] && !r.fctl[FC_CSPACE]) begin
            n.prog = PG_WRITE;
            n.arm  = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Launch needs write enable from before, code space and a code address
    if (n.fctl[FC_LAUNCH] && !r.fctl[FC_LAUNCH]) begin
      if (r.fctl[FC_WRITE_ENABLE_BIT] && n.fctl[FC_PSPACE] && !n.fctl[FC_CSPACE]
          && r.tp <= CODE_TOP) begin
        n.prog = n.fctl[FC_ERASE] ? PG_ERASE : PG_WRITE;
        n.arm  = 1'b1;
      end else begin
        n.fctl[FC_LAUNCH] = 1'b0;
      end
    end

    // Falling serial clock ends the programming hold
    if (hfall) begin
      n.prog            = PG_NONE;
      n.arm             = 1'b0;
      n.fctl[FC_LAUNCH] = 1'b0;
    end

    // Erase starts at the 4th clock of the NOP after the low selector write
    if (r.owner != OWN_IDLE && !r.busy && cev[pi] && r.erase_armed
        && lcmd[pi] == CMD_CORE) begin
      n.erase_armed = 1'b0;
      if (|m) begin
        n.busy  = 1'b1;
        n.ecnt  = ECNT_W'(ERASE_CYCLES - 1);
        n.emask = m;
        n.prot  = r.prot & ~{m[EM_DATA], m[EM_BOOT:0]};
        if (m[EM_CFG]) begin
          n.bsize = BSIZ_RST;
          if (r.owner == OWN_DEF) begin
            n.alt_bit = ALT_RST;
          end
        end
      end
    end else if (r.busy) begin
      if (r.ecnt == '0) begin
        n.busy  = 1'b0;
        n.emask = '0;
      end else begin
        n.ecnt = r.ecnt - ECNT_W'(1);
      end
    end

    // Session entry starts from a clean command state
    if (r.owner == OWN_IDLE) begin
      n.w           = '0;
      n.tp          = '0;
      n.fctl        = '0;
      n.sel_lo      = '0;
      n.sel_hi      = '0;
      n.erase_armed = 1'b0;
      n.prog        = PG_NONE;
      n.arm         = 1'b0;
    end

    n.sess = {n.owner == OWN_ALT, n.owner == OWN_DEF};
    n.armo = n.sess & {2{n.arm}};
    n.blim = boot_limit(n.bsize);
    n.blk  = (n.tp <= n.blim) ? BOOT_TAG : n.tp[BLOCK_SHIFT +: 3];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Read-out is not handled here, so the data pins are never driven
  assign prog_serial_data_pin_out    = 1'b0;
  assign prog_serial_data_pin_oe_out = 1'b0;
  assign alt_serial_data_pin_out     = 1'b0;
  assign alt_serial_data_pin_oe_out  = 1'b0;

  assign prog_owner_out             = r.owner;
  assign row_addr_out               = r.tp;
  assign row_block_out              = r.blk;
  assign row_write_out              = r.hd_s2[r.owner == OWN_ALT] && r.prog == PG_WRITE;
  assign row_erase_out              = r.hd_s2[r.owner == OWN_ALT] && r.prog == PG_ERASE;
  assign bulk_erase_busy_out        = r.busy;
  assign bulk_erase_regions_out     = r.emask;
  assign code_protect_out           = r.prot;
  assign flash_control_out          = r.fctl;
  assign bulk_erase_select_out      = {r.sel_hi, r.sel_lo};
  assign alt_port_enable_bit_out    = r.alt_bit;
  assign boot_region_size_field_out = r.bsize;
  assign boot_limit_out             = r.blim;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence launch_s;
    $rose(r.fctl[FC_LAUNCH]);
  endsequence

  sequence erase_start_s;
    $rose(r.busy);
  endsequence

  own_keep_a: assert property (r.owner == OWN_DEF && r.den_s2 |=> r.owner == OWN_DEF)
    else $error("default owner lost its session");

  def_entry_a: assert property (r.owner == OWN_IDLE && r.den_s2 |=> r.owner == OWN_DEF)
    else $error("default port did not take the session");

  alt_gate_a: assert property (r.owner == OWN_IDLE ##1 r.owner == OWN_ALT
    |-> $past(r.alt_bit) && $past(r.aen_s2))
    else $error("alternate session without enable bit");

  alt_lock_a: assert property (r.owner == OWN_ALT |=> $stable(r.alt_bit))
    else $error("alternate bit changed from alternate port");

  write_enable_bit_first_a: assert property (launch_s |-> $past(r.fctl[FC_WRITE_ENABLE_BIT]))
    else $error("launch accepted without prior write enable");

  code_space_a: assert property (launch_s |-> r.fctl[FC_PSPACE] && !r.fctl[FC_CSPACE]
    && r.arm)
    else $error("launch outside code space");

  row_erase_a: assert property (launch_s and r.fctl[FC_ERASE] |-> r.prog == PG_ERASE)
    else $error("erase-select launch not a row erase");

  prog_end_a: assert property ($fell(row_write_out || row_erase_out) && r.owner != OWN_IDLE
    |=> r.prog == PG_NONE && !r.fctl[FC_LAUNCH])
    else $error("programming did not end with the clock");

  erase_run_a: assert property (erase_start_s |-> r.busy[*8])
    else $error("bulk erase ended too early");

  erase_freeze_a: assert property (r.busy && n.owner != OWN_IDLE
    |=> $stable(r.tp) && $stable(r.w))
    else $error("command executed during bulk erase");

  prot_clear_a: assert property (|(r.prot & ~n.prot) |-> n.busy && !r.busy)
    else $error("protection cleared outside bulk erase");

  chip_dec_a: assert property (erase_start_s and {r.sel_hi, r.sel_lo} == SEL_CHIP
    |-> &r.emask)
    else $error("chip erase not decoded to all regions");

  blk_dec_a: assert property (erase_start_s and {r.sel_hi, r.sel_lo} == {8'h01, SEL_BLK_LO}
    |-> r.emask == 9'h001)
    else $error("block 0 selector misdecoded");
endmodule

// ==== test/spe_prog_model.sv ====
/*
  Programmer model for one serial port: shifts 20-bit frames.
  Assumes the device samples data on the falling serial clock.
*/
`timescale 1ns/10ps
module spe_prog_model (
  output logic sclk_out,
  output logic sdata_out
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
  end
  // Data moves mid-low phase so no edge ever sees it change
  task automatic frame(input logic [3:0] cmd, input logic [15:0] pay);
    logic [19:0] bits;
    bits = {pay, cmd};
    for (int i = 0; i < 20; i++) begin
      sdata_out = bits[i];
      #8 sclk_out = 1'b1;
      #15 sclk_out = 1'b0;
      #7;
    end
    sdata_out = 1'b0;
  endtask
  // Free clocks with data low; the link only resets or syncs its session on these
  task automatic idle(input int cnt);
    sdata_out = 1'b0;
    for (int i = 0; i < cnt; i++) begin
      #8 sclk_out = 1'b1;
      #15 sclk_out = 1'b0;
      #7;
    end
  endtask
endmodule

// ==== test/spe_ctrl_tb.sv ====
/*
  Self-checking bench for spe_ctrl: ownership, core writes, launch, erase.
  Assumes a 200 MHz core clock and serial frames from spe_prog_model.
*/
`timescale 1ns/10ps
module serial_program_erase_control_tb_top;
  import spe_pkg::*;
  logic        clk_in;
  logic        rst_b_in;
  logic        dflt_en;
  logic        alt_en;
  logic        dclk;
  logic        ddat;
  logic        aclk;
  logic        adat;
  logic [1:0]  owner;
  logic        busy;
  logic [8:0]  regions;
  logic [7:0]  fctl;
  logic [15:0] sel;
  logic [1:0]  bsize;
  logic [21:0] blim;
  logic [21:0] taddr;
  logic [2:0]  blk;
  logic        row_erase;
  logic [7:0]  prot;
  logic        alt_bit;
  logic        doe;
  logic        row_seen;
  int          fails;
  int          check_count;
  int          n;
  localparam int ERASE_N = 40;

  spe_prog_model dflt (.sclk_out(dclk), .sdata_out(ddat));
  spe_prog_model alt (.sclk_out(aclk), .sdata_out(adat));
  spe_ctrl #(.ERASE_CYCLES(ERASE_N)) uut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .default_prog_enable_pin_in(dflt_en),
    .alt_prog_enable_pin_in(alt_en), .prog_serial_clock_in(dclk),
    .prog_serial_data_pin_in(ddat), .prog_serial_data_pin_out(),
    .prog_serial_data_pin_oe_out(doe), .alt_serial_clock_pin_in(aclk),
    .alt_serial_data_pin_in(adat), .alt_serial_data_pin_out(),
    .alt_serial_data_pin_oe_out(), .prog_owner_out(owner), .row_addr_out(taddr),
    .row_block_out(blk), .row_write_out(), .row_erase_out(row_erase),
    .bulk_erase_busy_out(busy), .bulk_erase_regions_out(regions), .code_protect_out(prot),
    .flash_control_out(fctl), .bulk_erase_select_out(sel),
    .alt_port_enable_bit_out(alt_bit), .boot_region_size_field_out(bsize),
    .boot_limit_out(blim));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Row strobe lasts only while the serial clock is held, so latch it
  always @(negedge clk_in) begin
    if (!rst_b_in)
      row_seen <= 1'b0;
    else if (row_erase === 1'b1)
      row_seen <= 1'b1;
  end

  task automatic expect_eq(input logic [21:0] got, input logic [21:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic core(input logic [15:0] pay);
    dflt.frame(CMD_CORE, pay);
    repeat (8) @(posedge clk_in);
  endtask

  task automatic set_tp(input logic [21:0] a);
    core({8'h0e, 2'h0, a[21:16]});
    core({8'h6e, SFR_TPU});
    core({8'h0e, a[15:8]});
    core({8'h6e, SFR_TPH});
    core({8'h0e, a[7:0]});
    core({8'h6e, SFR_TPL});
  endtask

  task automatic test_owner();
    // Link flops have no reset of their own: clock them idle out of session
    fork
      dflt.idle(4);
      alt.idle(4);
    join
    @(posedge clk_in);
    expect_eq(owner, 2'h0, "owner after reset");
    expect_eq(bsize, 2'h1, "boot size reset");
    expect_eq(blim, BOOT_LIM_2K, "boot limit reset");
    dflt_en <= 1'b1;
    repeat (6) @(posedge clk_in);
    alt_en <= 1'b1;
    repeat (6) @(posedge clk_in);
    expect_eq(owner, 2'h1, "first enable owns");
    expect_eq(doe, 1'b0, "data pin not driven");
    // Exactly two clocks carry the session into the link before bit 0
    dflt.idle(2);
  endtask

  task automatic test_launch();
    core(16'h0e84);
    core({8'h6e, SFR_FCTL});
    expect_eq(fctl, 8'h84, "flash control load");
    core(16'h0e80);
    core({8'h6e, SFR_FCTL});
    core({8'h82, SFR_FCTL});
    expect_eq(fctl, 8'h80, "launch without write enable");
    core(16'h0e94);
    core({8'h6e, SFR_FCTL});
    core({8'h82, SFR_FCTL});
    expect_eq(fctl, 8'h96, "launch accepted");
    core(16'h0000);
    expect_eq(row_seen, 1'b1, "row erase strobe");
    expect_eq(fctl, 8'h94, "launch ends with clock");
  endtask

  task automatic test_config();
    set_tp(22'h001000);
    expect_eq(taddr, 22'h001000, "pointer load");
    expect_eq(blk, 3'h0, "block 0 above 2K boot");
    set_tp(CFG4L_ADDR);
    dflt.frame(CMD_TW, 16'h0004);
    set_tp(PROT_ADDR);
    dflt.frame(CMD_TW, 16'h00fe);
    set_tp(22'h001000);
    expect_eq(bsize, 2'h2, "boot size field");
    expect_eq(blim, BOOT_LIM_4K, "boot limit 4K");
    expect_eq(blk, 3'h7, "boot grew into block 0");
    expect_eq(prot, 8'h01, "block 0 protected");
    expect_eq(alt_bit, 1'b0, "alternate bit kept clear");
  endtask

  // Selector high then low, then NOP; busy watched on settled falling edges
  task automatic bulk(input logic [7:0] hi, input logic [7:0] lo, input logic [8:0] exp);
    set_tp(SEL_HI_ADDR);
    dflt.frame(CMD_TW, {hi, hi});
    set_tp(SEL_LO_ADDR);
    dflt.frame(CMD_TW, {lo, lo});
    repeat (8) @(posedge clk_in);
    expect_eq(sel, {hi, lo}, "selector value");
    fork
      dflt.frame(CMD_CORE, 16'h0000);
      begin
        n = 0;
        while (busy !== 1'b1 && n < 400) begin
          @(negedge clk_in);
          n++;
        end
        expect_eq(regions, exp, "erase regions");
        n = 0;
        while (busy === 1'b1 && n < 400) begin
          @(negedge clk_in);
          n++;
        end
        expect_eq(n, ERASE_N, "erase length");
      end
    join
    dflt.frame(CMD_CORE, 16'h0000);
    repeat (8) @(posedge clk_in);
  endtask

  task automatic test_block_erase();
    bulk(8'h01, SEL_BLK_LO, 9'h001);
    expect_eq(prot, 8'h00, "block erase unprotects");
    expect_eq(bsize, 2'h2, "block erase keeps config");
  endtask

  task automatic test_chip_erase();
    bulk(SEL_CHIP[15:8], SEL_CHIP[7:0], 9'h1ff);
    expect_eq(bsize, BSIZ_RST, "config erase resets boot size");
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  initial begin
    rst_b_in = 1'b0;
    dflt_en = 1'b0;
    alt_en = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    test_owner();
    test_launch();
    test_config();
    test_block_erase();
    test_chip_erase();
    print_verdict();
  end
endmodule
